// file: twr_checks.sv
`timescale 1ns/100ps
`include "twr_regs.svh"

// Contract
// - A too-early block start (readback data at inverted-NRZ) while writing sets sense byte 8 bit 3.
// - A too-short last-zero to record-gap interval also sets that bit.
// - At 1600 bpi an early start also raises data check.
// - When writing at 6250 bpi an early start raises equipment check.
// - Inverted-NRZ reads back as sense byte 6 bit 4 clear and bit 3 set.
// - Inverted-NRZ early window is 0.55 ms, 0.9 ms or 1.5 ms by model.
// - 6250 writes set sense byte 3 bit 1 at data end for 2+ fixed tracks.
// - 6250 writes set it for 2+ pointer tracks between resyncs, no drop.
// - A 6250 read sets it at data end only for more than two fixed tracks.
// - Phase-encoded reads set it for 2+ pointer tracks plus parity error.
// - Any track below usable amplitude also sets sense byte 3 bit 4.
// - Inverted-NRZ longitudinal parity failure sets the multi-track bit.
module twr_checks
   import twr_pkg::*;
#(
   parameter int NTRK     = 9,
   parameter int WIN_FAST = `TWR_CYC(`TWR_WIN_FAST_NS),
   parameter int WIN_MID  = `TWR_CYC(`TWR_WIN_MID_NS),
   parameter int WIN_SLOW = `TWR_CYC(`TWR_WIN_SLOW_NS),
   parameter int WIN_NORM = `TWR_CYC(`TWR_EARLY_NS),
   parameter int GAP_MIN  = `TWR_CYC(`TWR_GAP_MIN_NS)
) (
   // clock, reset, enable
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            ce_i,
   // wishbone slave
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   output logic                 wb_ack_o,
   // drive pins
   input  wire logic            block_start_seen_i,
   input  wire logic            readback_data_present_i,
   input  wire logic            last_zero_written_i,
   input  wire logic            record_gap_i,
   input  wire logic            end_of_data_time_i,
   input  wire logic            resync_burst_i,
   input  wire logic            time_sense_drop_i,
   input  wire logic            vertical_parity_check_i,
   input  wire logic            longitudinal_parity_register_i,
   input  wire logic [NTRK-1:0] track_corrected_i,
   input  wire logic [NTRK-1:0] track_pointer_i,
   input  wire logic [NTRK-1:0] track_amp_low_i,
   // status outputs
   output logic                 data_check_o,
   output logic                 equip_check_o,
   output logic                 irq_o
);
   localparam int SW  = 9 + 3 * NTRK;
   localparam int CW  = 18;

   // pin synchroniser
   logic [SW-1:0] sync1, sync2, prev;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
      end else if (ce_i) begin
         sync1 <= {block_start_seen_i, readback_data_present_i,
                   last_zero_written_i, record_gap_i, end_of_data_time_i,
                   resync_burst_i, time_sense_drop_i,
                   vertical_parity_check_i, longitudinal_parity_register_i,
                   track_corrected_i, track_pointer_i, track_amp_low_i};
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   logic [SW-1:0] rise;
   assign rise = sync2 & ~prev;
   localparam int B = 3 * NTRK;
   logic bst_r, fb_r, zero_r, gap_r, dend_r, rsy_r, drop_s, vpar_s, lrc_s;
   logic [NTRK-1:0] corr_s, ptr_s, amp_s;
   assign bst_r  = rise[B+8];
   assign fb_r   = rise[B+7];
   assign zero_r = rise[B+6];
   assign gap_r  = rise[B+5];
   assign dend_r = rise[B+4];
   assign rsy_r  = rise[B+3];
   assign drop_s = sync2[B+2];
   assign vpar_s = sync2[B+1];
   assign lrc_s  = sync2[B];
   assign corr_s = sync2[3*NTRK-1:2*NTRK];
   assign ptr_s  = sync2[2*NTRK-1:NTRK];
   assign amp_s  = sync2[NTRK-1:0];

   function automatic int popc(input logic [NTRK-1:0] v);
      int n;
      n = 0;
      for (int i = 0; i < NTRK; i++) begin
         n = n + int'(v[i]);
      end
      return n;
   endfunction

   // bus decode
   logic bus_req, wr_en, start;
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];
   assign start   = wr_en & (wb_adr_i == `TWR_CTRL_ADR)
                    & wb_dat_i[`TWR_CTRL_START];

   // operation control
   twr_state_e state, next_state;
   twr_op_e    op, next_op;
   twr_den_e   den, next_den;
   twr_mod_e   mdl, next_mdl;
   always_comb begin
      next_state = state;
      next_op    = op;
      next_den   = den;
      next_mdl   = mdl;
      if (wr_en && wb_adr_i == `TWR_CTRL_ADR) begin
         next_op  = twr_op_e'(wb_dat_i[`TWR_CTRL_OP_LO +: 2]);
         next_den = twr_den_e'(wb_dat_i[`TWR_CTRL_DEN_LO +: 2]);
         next_mdl = twr_mod_e'(wb_dat_i[`TWR_CTRL_MOD_LO +: 2]);
      end
      unique case (state)
         TWR_ST_IDLE: begin
            if (start) begin
               next_state = TWR_ST_RUN;
            end
         end
         TWR_ST_RUN: begin
            if (dend_r && !start) begin
               next_state = TWR_ST_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= TWR_ST_IDLE;
         op    <= TWR_OP_IDLE;
         den   <= TWR_DEN_NRZI;
         mdl   <= TWR_MOD_FAST;
      end else if (ce_i) begin
         state <= next_state;
         op    <= next_op;
         den   <= next_den;
         mdl   <= next_mdl;
      end
   end

   logic run, writing, nrzi;
   assign run     = (state == TWR_ST_RUN);
   assign writing = run & ((op == TWR_OP_WRITE) | (op == TWR_OP_WTM));
   assign nrzi    = (den == TWR_DEN_NRZI);

   // early window and fast-drive gap timers
   logic [CW-1:0] win_cnt, next_win_cnt, gap_cnt, next_gap_cnt, win_len;
   logic          gap_arm, next_gap_arm;
   logic [NTRK-1:0] ptr_acc, next_ptr_acc;
   logic          drop_seen, next_drop_seen;
   always_comb begin
      if (!nrzi) begin
         win_len = CW'(WIN_NORM);
      end else if (mdl == TWR_MOD_FAST) begin
         win_len = CW'(WIN_FAST);
      end else if (mdl == TWR_MOD_MID) begin
         win_len = CW'(WIN_MID);
      end else begin
         win_len = CW'(WIN_SLOW);
      end
      next_win_cnt = win_cnt;
      if (start) begin
         next_win_cnt = '0;
      end else if (run && win_cnt != '1) begin
         next_win_cnt = win_cnt + 1'b1;
      end
      next_gap_arm = gap_arm;
      next_gap_cnt = gap_cnt;
      if (start || gap_r) begin
         next_gap_arm = 1'b0;
      end else if (zero_r) begin
         next_gap_arm = 1'b1;
         next_gap_cnt = '0;
      end else if (gap_arm && gap_cnt != '1) begin
         next_gap_cnt = gap_cnt + 1'b1;
      end
      next_ptr_acc   = ptr_acc | ptr_s;
      next_drop_seen = drop_seen | drop_s;
      if (start || (rsy_r && den == TWR_DEN_6250)) begin
         next_ptr_acc   = '0;
         next_drop_seen = 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_cnt   <= '0;
         gap_cnt   <= '0;
         gap_arm   <= 1'b0;
         ptr_acc   <= '0;
         drop_seen <= 1'b0;
      end else if (ce_i) begin
         win_cnt   <= next_win_cnt;
         gap_cnt   <= next_gap_cnt;
         gap_arm   <= next_gap_arm;
         ptr_acc   <= next_ptr_acc;
         drop_seen <= next_drop_seen;
      end
   end

   // error events
   logic ev_early, ev_fast, ev_multi, ev_env, ev_dchk, ev_echk;
   logic [4:0] ev;
   always_comb begin
      ev_early = writing & (nrzi ? fb_r : bst_r) & (win_cnt < win_len);
      ev_fast  = writing & gap_arm & gap_r & (gap_cnt < CW'(GAP_MIN));
      ev_multi = 1'b0;
      if (run && den == TWR_DEN_6250 && writing) begin
         ev_multi = (dend_r & (popc(corr_s) >= 2))
                  | (rsy_r & (popc(ptr_acc) >= 2) & ~drop_seen);
      end else if (run && den == TWR_DEN_6250 && op == TWR_OP_READ) begin
         ev_multi = dend_r & (popc(corr_s) > 2);
      end else if (run && den == TWR_DEN_1600 && op == TWR_OP_READ) begin
         ev_multi = (popc(ptr_acc) >= 2) & vpar_s;
      end else if (run && nrzi) begin
         ev_multi = lrc_s;
      end
      ev_env  = run & (|amp_s);
      ev_dchk = (ev_early | ev_fast) & (den == TWR_DEN_1600);
      ev_echk = (ev_early | ev_fast) & (den == TWR_DEN_6250);
      ev = '0;
      ev[`TWR_EV_EARLY] = ev_early | ev_fast;
      ev[`TWR_EV_MULTI] = ev_multi;
      ev[`TWR_EV_ENV]   = ev_env;
      ev[`TWR_EV_DCHK]  = ev_dchk;
      ev[`TWR_EV_ECHK]  = ev_echk;
   end

   // sense bytes, checks and interrupt
   logic [7:0] sense3, next_sense3, sense8, next_sense8, sense6;
   logic [4:0] chk, next_chk, istat, next_istat, imask, next_imask;
   logic       next_irq;
   always_comb begin
      next_sense3 = start ? `TWR_SENSE_RST : sense3;
      next_sense8 = start ? `TWR_SENSE_RST : sense8;
      next_chk    = start ? 5'h00 : chk;
      next_sense3[`TWR_S3_MULTI] = next_sense3[`TWR_S3_MULTI] | ev_multi;
      next_sense3[`TWR_S3_ENV] = next_sense3[`TWR_S3_ENV] | ev_env;
      next_sense8[`TWR_S8_EARLY] = next_sense8[`TWR_S8_EARLY]
                                   | ev[`TWR_EV_EARLY];
      next_chk = next_chk | ev;
      next_imask = imask;
      next_istat = istat;
      if (wr_en && wb_adr_i == `TWR_IRQ_MASK_ADR) begin
         next_imask = wb_dat_i[4:0];
      end
      if (wr_en && wb_adr_i == `TWR_IRQ_STAT_ADR) begin
         next_istat = istat & ~wb_dat_i[4:0];
      end
      next_istat = next_istat | ev;
      next_irq   = |(next_istat & next_imask);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sense3        <= `TWR_SENSE_RST;
         sense8        <= `TWR_SENSE_RST;
         chk           <= 5'h00;
         istat         <= 5'h00;
         imask         <= 5'(`TWR_MASK_RST);
         irq_o         <= 1'b0;
         data_check_o  <= 1'b0;
         equip_check_o <= 1'b0;
      end else if (ce_i) begin
         sense3        <= next_sense3;
         sense8        <= next_sense8;
         chk           <= next_chk;
         istat         <= next_istat;
         imask         <= next_imask;
         irq_o         <= next_irq;
         data_check_o  <= next_chk[`TWR_EV_DCHK];
         equip_check_o <= next_chk[`TWR_EV_ECHK];
      end
   end

   // recording mode as reported in sense byte 6
   always_comb begin
      sense6 = 8'h00;
      sense6[`TWR_S6_B4] = ~nrzi;
      sense6[`TWR_S6_B3] = nrzi;
   end

   // bus read and acknowledge
   logic [31:0] next_dat;
   logic        next_ack;
   always_comb begin
      next_ack = bus_req;
      next_dat = wb_dat_o;
      if (bus_req) begin
         unique case (wb_adr_i)
            `TWR_CTRL_ADR: next_dat = {25'h0000000, mdl, den, op, 1'b0};
            `TWR_SENSE3_ADR: next_dat = {24'h000000, sense3};
            `TWR_SENSE6_ADR: next_dat = {24'h000000, sense6};
            `TWR_SENSE8_ADR: next_dat = {24'h000000, sense8};
            `TWR_CHECK_ADR: next_dat = {27'h0000000, chk};
            `TWR_IRQ_STAT_ADR: next_dat = {27'h0000000, istat};
            `TWR_IRQ_MASK_ADR: next_dat = {27'h0000000, imask};
            `TWR_STATUS_ADR: next_dat = {31'h00000000, run};
            default: next_dat = 32'h00000000;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end
endmodule

// file: twr_regs.svh
`ifndef TWR_REGS_SVH
`define TWR_REGS_SVH

// register byte offsets
`define TWR_CTRL_ADR      8'h00
`define TWR_SENSE3_ADR    8'h04
`define TWR_SENSE6_ADR    8'h08
`define TWR_SENSE8_ADR    8'h0C
`define TWR_CHECK_ADR     8'h10
`define TWR_IRQ_STAT_ADR  8'h14
`define TWR_IRQ_MASK_ADR  8'h18
`define TWR_STATUS_ADR    8'h1C

// control field positions
`define TWR_CTRL_START    0
`define TWR_CTRL_OP_LO    1
`define TWR_CTRL_DEN_LO   3
`define TWR_CTRL_MOD_LO   5

// sense field positions
`define TWR_S3_MULTI      1
`define TWR_S3_ENV        4
`define TWR_S6_B3         3
`define TWR_S6_B4         4
`define TWR_S8_EARLY      3

// check and event bit positions
`define TWR_EV_EARLY      0
`define TWR_EV_MULTI      1
`define TWR_EV_ENV        2
`define TWR_EV_DCHK       3
`define TWR_EV_ECHK       4

// reset values
`define TWR_SENSE_RST     8'h00
`define TWR_MASK_RST      8'h00

// timing
`define TWR_CLK_NS        20
`define TWR_WIN_FAST_NS   550000
`define TWR_WIN_MID_NS    900000
`define TWR_WIN_SLOW_NS   1500000
`define TWR_EARLY_NS      40000
`define TWR_GAP_MIN_NS    60000
`define TWR_CYC(ns) (((ns) + `TWR_CLK_NS - 1) / `TWR_CLK_NS)

`endif

// file: twr_pkg.sv
package twr_pkg;
   typedef enum logic [1:0] {
      TWR_OP_IDLE  = 2'b00,
      TWR_OP_WRITE = 2'b01,
      TWR_OP_WTM   = 2'b10,
      TWR_OP_READ  = 2'b11
   } twr_op_e;

   typedef enum logic [1:0] {
      TWR_DEN_NRZI = 2'b00,
      TWR_DEN_1600 = 2'b01,
      TWR_DEN_6250 = 2'b10,
      TWR_DEN_RSV  = 2'b11
   } twr_den_e;

   typedef enum logic [1:0] {
      TWR_MOD_FAST = 2'b00,
      TWR_MOD_MID  = 2'b01,
      TWR_MOD_SLOW = 2'b10,
      TWR_MOD_RSV  = 2'b11
   } twr_mod_e;

   typedef enum logic [0:0] {
      TWR_ST_IDLE = 1'b0,
      TWR_ST_RUN  = 1'b1
   } twr_state_e;
endpackage

// file: twr_checks_monitor.sv
`timescale 1ns/100ps
`include "twr_regs.svh"
module twr_checks_monitor
   import twr_pkg::*;
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   // bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // pins and status
   input wire logic        block_start_seen_i,
   input wire logic        readback_data_present_i,
   input wire logic        record_gap_i,
   input wire logic        data_check_o,
   input wire logic        equip_check_o,
   input wire logic        irq_o
);
   logic [7:0] since_ev;
   logic [7:0] next_since_ev;
   logic       wr_any;
   logic       ctrl_wr;

   assign wr_any  = wb_cyc_i & wb_stb_i & wb_we_i;
   assign ctrl_wr = wr_any & (wb_adr_i == `TWR_CTRL_ADR) & wb_dat_i[0];

   // cycles since an early-start cause was last high
   always_comb begin
      next_since_ev = since_ev + {7'h00, since_ev != 8'hFF};
      if (block_start_seen_i | readback_data_present_i | record_gap_i) begin
         next_since_ev = 8'h00;
      end
      if (rst_i) begin
         next_since_ev = 8'hFF;
      end
   end
   always_ff @(posedge clk_i) begin
      since_ev <= next_since_ev;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_ack_once: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack too long");
   chk_ack_prompt: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("ack late");
   chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_unmapped_zero: assert property
      (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1C |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_mode_code: assert property
      (wb_ack_o && !wb_we_i && wb_adr_i == `TWR_SENSE6_ADR
       |-> wb_dat_o[7:0] inside {8'h08, 8'h10})
      else $error("bad recording code");
   chk_dchk_hold: assert property ($fell(data_check_o) |->
      $past(ctrl_wr) || $past(ctrl_wr, 2))
      else $error("data check dropped");
   chk_echk_hold: assert property
      (equip_check_o && !ctrl_wr |=> equip_check_o)
      else $error("equip check dropped");
   chk_check_cause: assert property
      ($rose(data_check_o) || $rose(equip_check_o) |-> since_ev <= 8'h08)
      else $error("check without cause");
   chk_irq_clear: assert property
      ($fell(irq_o) |-> $past(wr_any) || $past(wr_any, 2))
      else $error("irq fell without write");
   chk_reset_clear: assert property ($fell(rst_i) |->
      !data_check_o && !equip_check_o && !irq_o)
      else $error("flags after reset");

   cover property ($rose(data_check_o));
   cover property ($rose(equip_check_o));
   cover property ($fell(irq_o));
endmodule

bind twr_checks twr_checks_monitor i_twr_checks_monitor (.*);

// file: twr_drive.sv
`timescale 1ns/100ps
module twr_drive (
   // clock
   input wire logic       clk_i,
   // pin levels towards the controller
   output logic     [9:0] ev_o,
   output logic     [8:0] trk_o
);
   initial begin
      ev_o = 10'h000;
      trk_o = 9'h000;
   end
   // tracks settle first; a gap follows a last zero by two cycles
   task automatic pulse(input int k, input logic [8:0] t);
      trk_o <= t;
      repeat (3) @(posedge clk_i);
      ev_o[k] <= 1'b1;
      if (k == 2) begin
         repeat (2) @(posedge clk_i);
         ev_o[3] <= 1'b1;
      end
      repeat (3) @(posedge clk_i);
      ev_o <= 10'h000;
      trk_o <= 9'h000;
   endtask
endmodule

// file: twr_checks_tb_top.sv
`timescale 1ns/100ps
`include "twr_regs.svh"
module twr_checks_tb_top
   import twr_pkg::*;
;
   localparam logic [7:0] S3 = `TWR_SENSE3_ADR, S6 = `TWR_SENSE6_ADR;
   localparam logic [7:0] S8 = `TWR_SENSE8_ADR, ST = `TWR_IRQ_STAT_ADR;
   localparam logic [7:0] MK = `TWR_IRQ_MASK_ADR;
   localparam twr_op_e  W = TWR_OP_WRITE, R = TWR_OP_READ, M = TWR_OP_WTM;
   localparam twr_den_e D0 = TWR_DEN_NRZI, D1 = TWR_DEN_1600;
   localparam twr_den_e D6 = TWR_DEN_6250;
   localparam twr_mod_e F = TWR_MOD_FAST;
   logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, data_check_o, equip_check_o, irq_o;
   wire         block_start_seen_i, readback_data_present_i;
   wire         last_zero_written_i, record_gap_i, end_of_data_time_i;
   wire         resync_burst_i, time_sense_drop_i, vertical_parity_check_i;
   wire         longitudinal_parity_register_i;
   wire  [8:0]  track_corrected_i, track_pointer_i, track_amp_low_i;
   logic [9:0]  ev;
   logic [8:0]  trk;
   int          failures = 0, comparisons = 0, cycles = 0;
   int          win[3] = '{40, 60, 80};

   always #10 clk_i = ~clk_i;

   twr_drive i_twr_drive (.clk_i(clk_i), .ev_o(ev), .trk_o(trk));
   assign {time_sense_drop_i, longitudinal_parity_register_i,
           vertical_parity_check_i, resync_burst_i, end_of_data_time_i,
           record_gap_i, last_zero_written_i, readback_data_present_i,
           block_start_seen_i} = {ev[9], ev[7:0]};
   assign track_amp_low_i = {8'h00, ev[8]};
   assign track_corrected_i = trk;
   assign track_pointer_i = trk;
   twr_checks #(.WIN_FAST(40), .WIN_MID(60), .WIN_SLOW(80), .WIN_NORM(20),
                .GAP_MIN(10)) i_twr_checks (.*);

   task automatic conclude;
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic bus(logic we, logic [7:0] a, logic [7:0] d,
                      output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk($sformatf("reg %h", a), q, {24'h0, e});
   endtask

   task automatic irq(logic e);
      chk("irq", {31'h0, irq_o}, {31'h0, e});
   endtask

   function automatic logic [7:0] c(twr_op_e o, twr_den_e d, twr_mod_e m);
      return {1'b0, m, d, o, 1'b1};
   endfunction

   // start an operation, wait, let the drive raise one pin (two for a last zero), then compare
   task automatic scen(logic [7:0] ctl, int k, int dly, logic [8:0] t,
                       logic [7:0] a, logic [7:0] e, logic dc, logic ec);
      wr(`TWR_CTRL_ADR, ctl);
      repeat (dly) @(posedge clk_i);
      i_twr_drive.pulse(k, t);
      repeat (8) @(posedge clk_i);
      rd(a, e);
      chk("data check", {31'h0, data_check_o}, {31'h0, dc});
      chk("equip check", {31'h0, equip_check_o}, {31'h0, ec});
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude;
      end
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wr(S8, 8'hFF);
      rd(S3, 8'h00);
      rd(S8, 8'h00);
      rd(S6, 8'h08);
      rd(MK, 8'h00);
      rd(8'h20, 8'h00);
      irq(1'b0);
      wr(MK, 8'h01);
      scen(c(W, D1, F), 0, 0, 0, S8, 8'h08, 1, 0);
      irq(1'b1);
      repeat (20) @(posedge clk_i);
      rd(S8, 8'h08);
      rd(ST, 8'h09);
      wr(MK, 8'h00);
      irq(1'b0);
      wr(MK, 8'h01);
      irq(1'b1);
      wr(ST, 8'h09);
      irq(1'b0);
      rd(ST, 8'h00);
      scen(c(W, D1, F), 0, 30, 0, S8, 8'h00, 0, 0);
      scen(c(M, D1, F), 0, 0, 0, S8, 8'h08, 1, 0);
      scen(c(R, D1, F), 0, 0, 0, S8, 8'h00, 0, 0);
      scen(c(W, D6, F), 0, 0, 0, S8, 8'h08, 0, 1);
      // reset in mid-run must drop the sticky flags
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("equip check", {31'h0, equip_check_o}, 32'h0);
      irq(1'b0);
      rd(S8, 8'h00);
      scen(c(W, D6, F), 2, 0, 0, S8, 8'h08, 0, 1);
      scen(c(W, D6, F), 4, 0, 9'h003, S3, 8'h02, 0, 0);
      scen(c(W, D6, F), 4, 0, 9'h001, S3, 8'h00, 0, 0);
      scen(c(W, D6, F), 5, 0, 9'h003, S3, 8'h02, 0, 0);
      // a sensor drop before the resync burst suppresses the flag
      wr(`TWR_CTRL_ADR, c(W, D6, F));
      i_twr_drive.pulse(9, 9'h003);
      @(posedge clk_i);
      i_twr_drive.pulse(5, 9'h003);
      repeat (8) @(posedge clk_i);
      rd(S3, 8'h00);
      // a pin pulse while the clock enable is low is never seen
      wr(`TWR_CTRL_ADR, c(W, D1, F));
      ce_i <= 1'b0;
      i_twr_drive.pulse(0, 9'h000);
      ce_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd(S8, 8'h00);
      chk("data check", {31'h0, data_check_o}, 32'h0);
      scen(c(R, D6, F), 4, 0, 9'h003, S3, 8'h00, 0, 0);
      scen(c(R, D6, F), 4, 0, 9'h007, S3, 8'h02, 0, 0);
      scen(c(W, D6, F), 8, 0, 0, S3, 8'h10, 0, 0);
      rd(S6, 8'h10);
      scen(c(R, D1, F), 6, 0, 9'h003, S3, 8'h02, 0, 0);
      scen(c(R, D1, F), 6, 0, 9'h001, S3, 8'h00, 0, 0);
      scen(c(R, D0, F), 7, 0, 0, S3, 8'h02, 0, 0);
      foreach (win[m]) begin
         scen(c(W, D0, twr_mod_e'(m)), 1, win[m] - 20, 0,
              S8, 8'h08, 0, 0);
         scen(c(W, D0, twr_mod_e'(m)), 1, win[m] + 10, 0,
              S8, 8'h00, 0, 0);
      end
      rd(S6, 8'h08);
      conclude;
   end
endmodule
